//--- include/clk_gate_pkg.sv
`default_nettype none
package clk_gate_pkg;
   localparam int unsigned addr_w = 12;
   localparam logic [11:0] run_gate_off = 12'h100;
   localparam logic [11:0] sleep_gate_off = 12'h110;
   localparam logic [11:0] deep_gate_off = 12'h120;
   localparam logic [11:0] run_cfg_off = 12'h060;
   localparam int unsigned pwm_bit = 20;
   localparam int unsigned hib_bit = 6;
   localparam int unsigned wdt_bit = 3;
   localparam int unsigned acg_bit = 27;
   localparam logic [31:0] gate_mask = 32'h0010_0048;
   localparam logic [31:0] gate_reset = 32'h0000_0040;
   localparam logic [31:0] cfg_mask = 32'h0800_0000;
   localparam logic [31:0] cfg_reset = 32'h0000_0000;
   localparam int unsigned num_units = 3;
   typedef enum logic [1:0] {mode_run, mode_sleep, mode_deep} power_mode_t;
   typedef struct packed {
      logic pwm;
      logic hibernation_gate;
      logic wdt;
   } unit_en_t;
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } apb_req_t;
endpackage
`default_nettype wire

//--- rtl/unit_clock_gate.sv
`default_nettype none
// Latch-based gate: enable changes only while the clock is low, so no glitch
module unit_clock_gate
(
   input wire logic clk_in,
   input wire logic enable,
   output logic clk_out
);
   logic en_latched;
   always_latch
   begin
      if (!clk_in)
         en_latched = enable;
   end
   assign clk_out = clk_in & en_latched;
endmodule // unit_clock_gate
`default_nettype wire

//--- rtl/low_power_clock_gating_regs.sv
`default_nettype none
// Operation
// - A set gating bit clocks its unit; a clear bit stops it.
// - Access to the PWM or watchdog unit while its clock is gated off gets a bus fault.
// - Gating bits reset to zero unless stated otherwise.
// - Printed reset 0x40 wins: hibernation bit resets to one.
// - Run register in run, sleep register in Sleep, deep register in Deep-Sleep.
// - Sleep and deep registers apply only with auto clock gating set.
// - Bit 20 gates the pulse-width modulator; its accesses fault when off.
// - Bit 6 gates the hibernation unit; no fault for it.
// - Bit 3 gates the watchdog; its accesses fault when off.
// - All other bits read as zero and ignore writes.
// - Sleep register at 0x110, deep-sleep register at 0x120.
// - Run register at 0x100 with the same layout.
module low_power_clock_gating_regs
   import clk_gate_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_req,
   input wire logic deep_sleep_req,
   input wire logic unit_access_pwm,
   input wire logic unit_access_wdt,
   output logic unit_fault_pwm,
   output logic unit_fault_wdt,
   output logic clk_pwm,
   output logic clk_hib,
   output logic clk_wdt,
   output clk_gate_pkg::unit_en_t unit_en
);
   logic [31:0] run_gate_ff;
   logic [31:0] sleep_gate_ff;
   logic [31:0] deep_gate_ff;
   logic [31:0] run_cfg_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic pslverr_ff;
   logic [1:0] sleep_sync_ff;
   logic [1:0] deep_sync_ff;
   power_mode_t mode_ff;
   power_mode_t nxt_mode;
   unit_en_t en_ff;
   logic fault_pwm_ff;
   logic fault_wdt_ff;
   wire logic access = psel & penable;
   wire logic wr = access & pwrite;
   wire logic hit_run = paddr == run_gate_off;
   wire logic hit_sleep = paddr == sleep_gate_off;
   wire logic hit_deep = paddr == deep_gate_off;
   wire logic hit_cfg = paddr == run_cfg_off;
   wire logic hit_any = hit_run | hit_sleep | hit_deep | hit_cfg;
   wire logic auto_gate = run_cfg_ff[acg_bit];
   wire logic [31:0] active_gate;
   unit_en_t nxt_en;

   // Pins from the power controller are synchronised first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sleep_sync_ff <= 2'h0;
         deep_sync_ff <= 2'h0;
      end
      else
      begin
         sleep_sync_ff <= {sleep_sync_ff[0], sleep_req};
         deep_sync_ff <= {deep_sync_ff[0], deep_sleep_req};
      end
   end

   // Deep-Sleep outranks Sleep when both are requested
   assign nxt_mode = deep_sync_ff[1] ? mode_deep : (sleep_sync_ff[1] ? mode_sleep : mode_run);

   assign active_gate = (!auto_gate || mode_ff == mode_run) ? run_gate_ff :
                        (mode_ff == mode_sleep) ? sleep_gate_ff : deep_gate_ff;
   assign nxt_en.pwm = active_gate[pwm_bit];
   assign nxt_en.hibernation_gate = active_gate[hib_bit];
   assign nxt_en.wdt = active_gate[wdt_bit];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_ff <= mode_run;
         en_ff <= '0;
      end
      else
      begin
         mode_ff <= nxt_mode;
         en_ff <= nxt_en;
      end
   end
   assign unit_en = en_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_gate_ff <= gate_reset;
         sleep_gate_ff <= gate_reset;
         deep_gate_ff <= gate_reset;
         run_cfg_ff <= cfg_reset;
      end
      else if (wr)
      begin
         if (hit_run)
            run_gate_ff <= pwdata & gate_mask;
         if (hit_sleep)
            sleep_gate_ff <= pwdata & gate_mask;
         if (hit_deep)
            deep_gate_ff <= pwdata & gate_mask;
         if (hit_cfg)
            run_cfg_ff <= pwdata & cfg_mask;
      end
   end

   assign nxt_prdata = hit_run ? run_gate_ff : hit_sleep ? sleep_gate_ff :
                       hit_deep ? deep_gate_ff : hit_cfg ? run_cfg_ff : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         if (psel && !penable && !pwrite)
            prdata_ff <= nxt_prdata;
         if (psel && !penable)
            pslverr_ff <= !hit_any;
      end
   end
   // Zero-wait slave; unmapped addresses answer with pslverr
   assign pready = 1'b1;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff & access;

   // Faults registered one cycle after the unit access strobe
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fault_pwm_ff <= 1'b0;
         fault_wdt_ff <= 1'b0;
      end
      else
      begin
         fault_pwm_ff <= unit_access_pwm & ~en_ff.pwm;
         fault_wdt_ff <= unit_access_wdt & ~en_ff.wdt;
      end
   end
   assign unit_fault_pwm = fault_pwm_ff;
   assign unit_fault_wdt = fault_wdt_ff;

   // Glitch-free gates, so a mode switch never chops a pulse
   // Bit order follows the enable struct: pwm, hib, wdt
   wire logic [2:0] gate_en = en_ff;
   logic [2:0] gated_clk;
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_unit_gate
         unit_clock_gate u_gate
         (
            .clk_in(pclk),
            .enable(gate_en[g]),
            .clk_out(gated_clk[g])
         );
      end
   endgenerate
   assign clk_pwm = gated_clk[2];
   assign clk_hib = gated_clk[1];
   assign clk_wdt = gated_clk[0];

   // Bus phases that the register checks are built from
   sequence s_setup_read;
      psel && !penable && !pwrite;
   endsequence

   sequence s_setup_any;
      psel && !penable;
   endsequence

   sequence s_access;
      psel && penable;
   endsequence

   // Reset checks carry no disable, they must see the release itself
   a_reset_hib_on: assert property (
      @(posedge pclk) $rose(presetn) |-> run_gate_ff == gate_reset)
      else $error("gate reset value wrong");

   a_reset_en_off: assert property (
      @(posedge pclk) $rose(presetn) |-> unit_en == 3'h0)
      else $error("unit enabled during reset");

   a_hib_after_rst: assert property (
      @(posedge pclk) $rose(presetn) |=> unit_en.hibernation_gate)
      else $error("hibernation clock not on after reset");

   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      ((sleep_gate_ff | deep_gate_ff | run_gate_ff) & ~gate_mask) == 32'h0)
      else $error("reserved bit set");

   a_cfg_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      (run_cfg_ff & ~cfg_mask) == 32'h0)
      else $error("config reserved bit set");

   a_run_in_force: assert property (@(posedge pclk) disable iff (!presetn)
      !auto_gate |=> en_ff.pwm == $past(run_gate_ff[pwm_bit]))
      else $error("run gating not applied");

   a_run_hib: assert property (@(posedge pclk) disable iff (!presetn)
      (!auto_gate || mode_ff == mode_run) |=> en_ff.hibernation_gate == $past(run_gate_ff[hib_bit]))
      else $error("run hibernation gating not applied");

   a_deep_applied: assert property (@(posedge pclk) disable iff (!presetn)
      (auto_gate && mode_ff == mode_deep) |=> en_ff.wdt == $past(deep_gate_ff[wdt_bit]))
      else $error("deep gating not applied");

   a_deep_pwm: assert property (@(posedge pclk) disable iff (!presetn)
      (auto_gate && mode_ff == mode_deep) |=> en_ff.pwm == $past(deep_gate_ff[pwm_bit]))
      else $error("deep pwm gating not applied");

   a_sleep_applied: assert property (@(posedge pclk) disable iff (!presetn)
      (auto_gate && mode_ff == mode_sleep) |=> en_ff.hibernation_gate == $past(sleep_gate_ff[hib_bit]))
      else $error("sleep gating not applied");

   a_sleep_wdt: assert property (@(posedge pclk) disable iff (!presetn)
      (auto_gate && mode_ff == mode_sleep) |=> en_ff.wdt == $past(sleep_gate_ff[wdt_bit]))
      else $error("sleep wdt gating not applied");

   a_mode_deep: assert property (@(posedge pclk) disable iff (!presetn)
      deep_sync_ff[1] |=> mode_ff == mode_deep)
      else $error("deep request not taken");

   a_mode_sleep: assert property (@(posedge pclk) disable iff (!presetn)
      (sleep_sync_ff[1] && !deep_sync_ff[1]) |=> mode_ff == mode_sleep)
      else $error("sleep request not taken");

   a_mode_run: assert property (@(posedge pclk) disable iff (!presetn)
      (!sleep_sync_ff[1] && !deep_sync_ff[1]) |=> mode_ff == mode_run)
      else $error("run mode not restored");

   a_pwm_fault: assert property (@(posedge pclk) disable iff (!presetn)
      (unit_access_pwm && !en_ff.pwm) |=> unit_fault_pwm)
      else $error("pwm fault missing");

   a_pwm_no_fault: assert property (@(posedge pclk) disable iff (!presetn)
      (unit_access_pwm && en_ff.pwm) |=> !unit_fault_pwm)
      else $error("spurious pwm fault");

   a_pwm_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !unit_access_pwm |=> !unit_fault_pwm)
      else $error("pwm fault without access");

   a_wdt_fault: assert property (@(posedge pclk) disable iff (!presetn)
      (unit_access_wdt && en_ff.wdt) |=> !unit_fault_wdt)
      else $error("spurious wdt fault");

   a_wdt_fault_set: assert property (@(posedge pclk) disable iff (!presetn)
      (unit_access_wdt && !en_ff.wdt) |=> unit_fault_wdt)
      else $error("wdt fault missing");

   a_wdt_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !unit_access_wdt |=> !unit_fault_wdt)
      else $error("wdt fault without access");

   a_sleep_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_sleep) |=> sleep_gate_ff == ($past(pwdata) & gate_mask))
      else $error("sleep write lost");

   a_deep_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_deep) |=> deep_gate_ff == ($past(pwdata) & gate_mask))
      else $error("deep write lost");

   a_run_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_run) |=> run_gate_ff == ($past(pwdata) & gate_mask))
      else $error("run write lost");

   a_cfg_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_cfg) |=> run_cfg_ff == ($past(pwdata) & cfg_mask))
      else $error("config write lost");

   // A register only moves on a landed write
   a_idle_stable: assert property (@(posedge pclk) disable iff (!presetn)
      !wr |=> ($stable(run_gate_ff) && $stable(sleep_gate_ff) && $stable(deep_gate_ff)))
      else $error("gate register moved without write");

   a_unmapped_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && !hit_any) |=> ($stable(run_gate_ff) && $stable(sleep_gate_ff) &&
      $stable(deep_gate_ff) && $stable(run_cfg_ff)))
      else $error("unmapped write landed");

   a_read_sleep: assert property (@(posedge pclk) disable iff (!presetn)
      (s_setup_read and hit_sleep) |=> prdata == sleep_gate_ff)
      else $error("sleep read data wrong");

   a_read_deep: assert property (@(posedge pclk) disable iff (!presetn)
      (s_setup_read and hit_deep) |=> prdata == deep_gate_ff)
      else $error("deep read data wrong");

   a_read_run: assert property (@(posedge pclk) disable iff (!presetn)
      (s_setup_read and hit_run) |=> prdata == run_gate_ff)
      else $error("run read data wrong");

   a_read_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      (s_setup_read and !hit_any) |=> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   // Error answer belongs to the access phase of the same transfer only
   a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      (s_setup_any and !hit_any) ##1 s_access |-> pslverr)
      else $error("unmapped access not refused");

   a_ok_mapped: assert property (@(posedge pclk) disable iff (!presetn)
      (s_setup_any and hit_any) ##1 s_access |-> !pslverr)
      else $error("mapped access refused");
endmodule // low_power_clock_gating_regs
`default_nettype wire

//--- sim/unit_side_model.sv
`default_nettype none
module unit_side_model
(
   input wire logic clk_pwm,
   input wire logic go_pwm,
   input wire logic go_wdt,
   output logic unit_access_pwm,
   output logic unit_access_wdt,
   output int pwm_ticks
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus traffic reaches a unit as a level; the gating block judges the fault
   assign unit_access_pwm = go_pwm;
   assign unit_access_wdt = go_wdt;
   initial pwm_ticks = 0;
   // Counts only edges that really arrive, so a stopped clock shows up
   always @(posedge clk_pwm) pwm_ticks <= pwm_ticks + 1;
endmodule // unit_side_model
`default_nettype wire

//--- sim/test_low_power_clock_gating_regs.sv
`default_nettype none
module test_low_power_clock_gating_regs import clk_gate_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic sleep_req = 0, deep_sleep_req = 0, go_pwm = 0, go_wdt = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic pready, pslverr, unit_access_pwm, unit_access_wdt;
   logic unit_fault_pwm, unit_fault_wdt, clk_pwm, clk_hib, clk_wdt;
   int hib_ticks = 0, wdt_ticks = 0, t1, t2;
   unit_en_t unit_en;
   int fail_count = 0, n_tests = 0, seed = 32'hf0c7, t0, pwm_ticks;
   logic [32:0] q[$];
   logic [11:0] offs[3] = '{run_gate_off, sleep_gate_off, deep_gate_off};
   low_power_clock_gating_regs low_power_clock_gating_regs_inst (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_req,
      .deep_sleep_req, .unit_access_pwm, .unit_access_wdt, .unit_fault_pwm,
      .unit_fault_wdt, .clk_pwm, .clk_hib, .clk_wdt, .unit_en);
   // Edges that really reach the other two units
   always @(posedge clk_hib) hib_ticks <= hib_ticks + 1;
   always @(posedge clk_wdt) wdt_ticks <= wdt_ticks + 1;
   unit_side_model unit_side_model_inst (.clk_pwm, .go_pwm, .go_wdt, .unit_access_pwm,
      .unit_access_wdt, .pwm_ticks);
   initial forever #2.5 pclk = ~pclk;
   task check(input logic [32:0] got, input logic [32:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      if (fail_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      if (!w) q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wt(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task acc(input logic [1:0] e);
      @(posedge pclk);
      go_pwm <= 1'b1;
      go_wdt <= 1'b1;
      @(posedge pclk);
      go_pwm <= 1'b0;
      go_wdt <= 1'b0;
      #1 check({31'h0, unit_fault_pwm, unit_fault_wdt}, {31'h0, e});
   endtask
   // Read results are matched in issue order, whatever the read latency
   always @(posedge pclk)
      if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0)
         check({pslverr, prdata}, q.pop_front());
   initial
   begin
      repeat (3000) @(posedge pclk);
      fail_count++;
      tally_and_finish;
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wt(2);
      check(33'(unit_en), 33'h2);
      for (int i = 0; i < 3; i++)
         apb(1'b0, offs[i], 32'h0, {1'b0, gate_reset});
      apb(1'b0, run_cfg_off, 32'h0, {1'b0, cfg_reset});
      apb(1'b0, 12'h0FC, 32'h0, {1'b1, 32'h0});
      for (int i = 0; i < 3; i++)
      begin
         d = $random(seed);
         apb(1'b1, offs[i], d, 33'h0);
         apb(1'b0, offs[i], 32'h0, {1'b0, d & gate_mask});
      end
      apb(1'b1, run_gate_off, 32'h0, 33'h0);
      acc(2'b11);
      t0 = pwm_ticks;
      t1 = hib_ticks;
      t2 = wdt_ticks;
      wt(10);
      check({30'h0, pwm_ticks != t0, hib_ticks != t1, wdt_ticks != t2}, 33'h0);
      apb(1'b1, run_gate_off, 32'hFFFF_FFFF, 33'h0);
      acc(2'b00);
      t0 = pwm_ticks;
      t1 = hib_ticks;
      t2 = wdt_ticks;
      wt(10);
      check({30'h0, pwm_ticks != t0, hib_ticks != t1, wdt_ticks != t2}, 33'h7);
      apb(1'b1, sleep_gate_off, 32'h0000_0040, 33'h0);
      apb(1'b1, deep_gate_off, 32'h0000_0008, 33'h0);
      @(posedge pclk);
      sleep_req <= 1'b1;
      wt(8);
      check(33'(unit_en), 33'h7);
      apb(1'b1, run_cfg_off, cfg_mask, 33'h0);
      wt(8);
      check(33'(unit_en), 33'h2);
      @(posedge pclk);
      deep_sleep_req <= 1'b1;
      wt(8);
      check(33'(unit_en), 33'h1);
      @(posedge pclk);
      sleep_req <= 1'b0;
      deep_sleep_req <= 1'b0;
      wt(8);
      check(33'(unit_en), 33'h7);
      tally_and_finish;
   end
endmodule // test_low_power_clock_gating_regs
`default_nettype wire
